// ==== flash_timing_pkg.sv ====
// Constants, types and timing figures for the flash program/erase timing generator.
//
// Behaviour
// - Program pulse lasts clock period x (prescale+1) x (program count+1).
// - Erase pulse lasts clock period x (prescale+1) x 4 x (erase count+1).
// - Start delay lasts clock period x (prescale+1) x (start count+1).
// - Transition interval lasts clock period x (prescale+1) x (transition count+1).
// - End delay lasts clock period x (prescale+1) x (end count+1).
// - Data memory has its own six timing values, used with identical formulas.
// - Program-memory address held, new address set up, at least 2 clocks.
// - Charge pump enable held at least 1 clock around each operation.
// - ISP memory uses the data-memory timing values, no set of its own.
package flash_timing_pkg;

  localparam int PRESCALE_W       = 8;
  localparam int COUNT_W          = 8;
  localparam int ADDR_W           = 16;
  localparam int ERASE_SHIFT      = 2;   // Erase pulse runs four times (count+1) ticks.
  localparam int ERASE_W          = COUNT_W + ERASE_SHIFT;
  localparam int CYC_W            = PRESCALE_W + ERASE_W + 1;
  localparam int ADDR_HOLD_CYCLES = 2;
  localparam int PUMP_HOLD_CYCLES = 1;

  // Clock and the printed windows that software must meet.
  localparam int CLK_PERIOD_NS    = 10;
  localparam int PROG_MIN_NS      = 30000;
  localparam int PROG_MAX_NS      = 40000;
  localparam int ERASE_MIN_NS     = 1000000;
  localparam int START_MIN_NS     = 10000;
  localparam int TRAN_MIN_NS      = 5000;
  localparam int END_MIN_NS       = 5000;
  localparam int PROG_MIN_CYCLES  = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_MAX_CYCLES  = PROG_MAX_NS / CLK_PERIOD_NS;
  localparam int ERASE_MIN_CYCLES = (ERASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_MIN_CYCLES = (START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRAN_MIN_CYCLES  = (TRAN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int END_MIN_CYCLES   = (END_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ARRAY_PMEM,
    ARRAY_DMEM,
    ARRAY_ISP
  } array_sel_t;

  typedef enum logic {
    OP_PROGRAM,
    OP_ERASE
  } flash_op_t;

  // One array's set of timing values.
  typedef struct packed {
    logic [PRESCALE_W-1:0] timing_prescale_value;
    logic [COUNT_W-1:0]    program_pulse_count;
    logic [COUNT_W-1:0]    erase_pulse_count;
    logic [COUNT_W-1:0]    start_delay_count;
    logic [COUNT_W-1:0]    transition_delay_count;
    logic [COUNT_W-1:0]    end_delay_count;
  } timing_set_t;

  // An operation request.
  typedef struct packed {
    array_sel_t        array;
    flash_op_t         op;
    logic [ADDR_W-1:0] addr;
  } op_request_t;

endpackage

// ==== prescaled_down_counter.sv ====
// Prescaled down-counter that times one phase of a flash operation.
`timescale 1ns/1ps
module prescaled_down_counter (
  input  wire logic                                    clk_sys,
  input  wire logic                                    rst,
  input  wire logic                                    load,
  input  wire logic [flash_timing_pkg::PRESCALE_W-1:0] prescale,
  input  wire logic [flash_timing_pkg::ERASE_W-1:0]    count,
  output logic                                         expire
);
  import flash_timing_pkg::*;

  logic [PRESCALE_W-1:0] pre;
  logic [PRESCALE_W-1:0] next_pre;
  logic [ERASE_W-1:0]    cnt;
  logic [ERASE_W-1:0]    next_cnt;
  logic                  running;
  logic                  next_running;
  logic                  next_expire;

  // Each tick takes prescale+1 clocks; the phase ends after count+1 ticks.
  always_comb begin
    next_pre     = pre;
    next_cnt     = cnt;
    next_running = running;
    next_expire  = 1'b0;
    if (load) begin
      next_pre     = prescale;
      next_cnt     = count;
      next_running = 1'b1;
    end else if (running) begin
      if (pre != '0) begin
        next_pre = pre - 1'b1;
      end else begin
        next_pre = prescale;
        if (cnt == '0) begin
          next_running = 1'b0;
          next_expire  = 1'b1;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
    end
  end

  // Registers the counter state.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pre     <= '0;
      cnt     <= '0;
      running <= 1'b0;
      expire  <= 1'b0;
    end else begin
      pre     <= next_pre;
      cnt     <= next_cnt;
      running <= next_running;
      expire  <= next_expire;
    end
  end

endmodule // prescaled_down_counter

// ==== flash_program_erase_timing.sv ====
// Sequencer that times charge pump, program and erase pulses for the flash arrays.
`timescale 1ns/1ps
module flash_program_erase_timing #(
  parameter int ADDR_HOLD       = flash_timing_pkg::ADDR_HOLD_CYCLES,
  parameter int PROG_MIN_CYC    = flash_timing_pkg::PROG_MIN_CYCLES,
  parameter int PROG_MAX_CYC    = flash_timing_pkg::PROG_MAX_CYCLES,
  parameter int ERASE_MIN_CYC   = flash_timing_pkg::ERASE_MIN_CYCLES,
  parameter int START_MIN_CYC   = flash_timing_pkg::START_MIN_CYCLES,
  parameter int TRAN_MIN_CYC    = flash_timing_pkg::TRAN_MIN_CYCLES,
  parameter int END_MIN_CYC     = flash_timing_pkg::END_MIN_CYCLES
) (
  input  wire logic                                    clk_sys,
  input  wire logic                                    rst,
  input  wire logic [flash_timing_pkg::PRESCALE_W-1:0] pmem_prescale_reg,
  input  wire logic [flash_timing_pkg::COUNT_W-1:0]    pmem_program_time_reg,
  input  wire logic [flash_timing_pkg::COUNT_W-1:0]    pmem_erase_time_reg,
  input  wire logic [flash_timing_pkg::COUNT_W-1:0]    pmem_start_time_reg,
  input  wire logic [flash_timing_pkg::COUNT_W-1:0]    pmem_transition_time_reg,
  input  wire logic [flash_timing_pkg::COUNT_W-1:0]    pmem_end_time_reg,
  input  wire logic [flash_timing_pkg::PRESCALE_W-1:0] dmem_prescale_reg,
  input  wire logic [flash_timing_pkg::COUNT_W-1:0]    dmem_program_time_reg,
  input  wire logic [flash_timing_pkg::COUNT_W-1:0]    dmem_erase_time_reg,
  input  wire logic [flash_timing_pkg::COUNT_W-1:0]    dmem_start_time_reg,
  input  wire logic [flash_timing_pkg::COUNT_W-1:0]    dmem_transition_time_reg,
  input  wire logic [flash_timing_pkg::COUNT_W-1:0]    dmem_end_time_reg,
  input  wire logic                                    op_start,
  input  wire flash_timing_pkg::op_request_t           op_request,
  output logic                                         busy,
  output logic                                         op_done,
  output logic                                         op_refused,
  output logic                                         timing_warning,
  output logic                                         pump_enable,
  output logic                                         program_pulse,
  output logic                                         erase_pulse,
  output flash_timing_pkg::array_sel_t                 array_select,
  output logic [flash_timing_pkg::ADDR_W-1:0]          flash_addr
);
  import flash_timing_pkg::*;

  typedef enum {
    ST_IDLE,
    ST_PUMP_LEAD,
    ST_START,
    ST_TRAN_IN,
    ST_PULSE,
    ST_TRAN_OUT,
    ST_END,
    ST_PUMP_TRAIL,
    ST_ADDR_GAP
  } seq_state_t;

  localparam logic [1:0] GAP_LAST = 2'(ADDR_HOLD - 1);

  // Cycles taken by a phase: (prescale+1) x (count+1).
  function automatic logic [CYC_W-1:0] phase_cycles(input logic [PRESCALE_W-1:0] p,
                                                    input logic [ERASE_W-1:0]    c);
    phase_cycles = CYC_W'((CYC_W'(p) + 1'b1) * (CYC_W'(c) + 1'b1));
  endfunction

  // Erase count scaled by four: 4 x (n+1) - 1 ticks below the top.
  function automatic logic [ERASE_W-1:0] erase_ticks(input logic [COUNT_W-1:0] n);
    erase_ticks = {n, {ERASE_SHIFT{1'b1}}};
  endfunction

  timing_set_t pmem_set;
  timing_set_t dmem_set;
  timing_set_t sel_set;
  timing_set_t op_set;
  timing_set_t next_op_set;
  seq_state_t  state;
  seq_state_t  next_state;
  flash_op_t   op_kind;
  flash_op_t   next_op_kind;
  logic [1:0]  gap_cnt;
  logic [1:0]  next_gap_cnt;
  logic        timer_load;
  logic [ERASE_W-1:0] timer_count;
  logic        timer_expire;
  logic        warn_now;
  logic        next_busy;
  logic        next_op_done;
  logic        next_op_refused;
  logic        next_timing_warning;
  logic        next_pump_enable;
  logic        next_program_pulse;
  logic        next_erase_pulse;
  array_sel_t  next_array_select;
  logic [ADDR_W-1:0] next_flash_addr;

  // Two register sets; ISP memory shares the data-memory set.
  assign pmem_set = '{pmem_prescale_reg, pmem_program_time_reg, pmem_erase_time_reg,
                      pmem_start_time_reg, pmem_transition_time_reg, pmem_end_time_reg};
  assign dmem_set = '{dmem_prescale_reg, dmem_program_time_reg, dmem_erase_time_reg,
                      dmem_start_time_reg, dmem_transition_time_reg, dmem_end_time_reg};
  assign sel_set  = (op_request.array == ARRAY_PMEM) ? pmem_set : dmem_set;

  // Flags a requested set that misses the windows software must meet.
  always_comb begin
    warn_now = 1'b0;
    if (op_request.op == OP_PROGRAM) begin
      if (phase_cycles(sel_set.timing_prescale_value,
                       ERASE_W'(sel_set.program_pulse_count)) < CYC_W'(PROG_MIN_CYC) ||
          phase_cycles(sel_set.timing_prescale_value,
                       ERASE_W'(sel_set.program_pulse_count)) > CYC_W'(PROG_MAX_CYC)) begin
        warn_now = 1'b1;
      end
    end else if (phase_cycles(sel_set.timing_prescale_value,
                              erase_ticks(sel_set.erase_pulse_count))
                 < CYC_W'(ERASE_MIN_CYC)) begin
      warn_now = 1'b1;
    end
    if (phase_cycles(sel_set.timing_prescale_value,
                     ERASE_W'(sel_set.start_delay_count)) < CYC_W'(START_MIN_CYC) ||
        phase_cycles(sel_set.timing_prescale_value,
                     ERASE_W'(sel_set.transition_delay_count)) < CYC_W'(TRAN_MIN_CYC) ||
        phase_cycles(sel_set.timing_prescale_value,
                     ERASE_W'(sel_set.end_delay_count)) < CYC_W'(END_MIN_CYC)) begin
      warn_now = 1'b1;
    end
  end

  // Sequencer: pump lead, start, transition, pulse, transition, end, pump trail, gap.
  always_comb begin
    next_state          = state;
    next_op_set         = op_set;
    next_op_kind        = op_kind;
    next_gap_cnt        = gap_cnt;
    next_flash_addr     = flash_addr;
    next_array_select   = array_select;
    next_timing_warning = timing_warning;
    next_op_done        = 1'b0;
    next_op_refused     = 1'b0;
    timer_load          = 1'b0;
    timer_count         = '0;
    case (state)
      ST_IDLE: begin
        if (op_start) begin
          next_op_set         = sel_set;
          next_op_kind        = op_request.op;
          next_flash_addr     = op_request.addr;
          next_array_select   = op_request.array;
          next_timing_warning = warn_now;
          next_state          = ST_PUMP_LEAD;
        end
      end
      ST_PUMP_LEAD: begin
        timer_load  = 1'b1;
        timer_count = ERASE_W'(op_set.start_delay_count);
        next_state  = ST_START;
      end
      ST_START: begin
        if (timer_expire) begin
          timer_load  = 1'b1;
          timer_count = ERASE_W'(op_set.transition_delay_count);
          next_state  = ST_TRAN_IN;
        end
      end
      ST_TRAN_IN: begin
        if (timer_expire) begin
          timer_load = 1'b1;
          if (op_kind == OP_PROGRAM) begin
            timer_count = ERASE_W'(op_set.program_pulse_count);
          end else begin
            timer_count = erase_ticks(op_set.erase_pulse_count);
          end
          next_state = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (timer_expire) begin
          timer_load  = 1'b1;
          timer_count = ERASE_W'(op_set.transition_delay_count);
          next_state  = ST_TRAN_OUT;
        end
      end
      ST_TRAN_OUT: begin
        if (timer_expire) begin
          timer_load  = 1'b1;
          timer_count = ERASE_W'(op_set.end_delay_count);
          next_state  = ST_END;
        end
      end
      ST_END: begin
        if (timer_expire) begin
          next_state = ST_PUMP_TRAIL;
        end
      end
      ST_PUMP_TRAIL: begin
        next_gap_cnt = '0;
        next_op_done = 1'b1;
        next_state   = ST_ADDR_GAP;
      end
      ST_ADDR_GAP: begin
        // Address stays put for the hold time before a new one is accepted.
        if (gap_cnt == GAP_LAST) begin
          next_state = ST_IDLE;
        end else begin
          next_gap_cnt = gap_cnt + 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (op_start && state != ST_IDLE) begin
      next_op_refused = 1'b1;
    end
  end

  // Output levels follow the next state so that they leave flip-flops aligned to it.
  // The pulse phase lasts one cycle more than its formula because the timer's expire is
  // registered, so the pulse outputs skip the phase's first cycle and stand exactly as long.
  always_comb begin
    next_busy          = (next_state != ST_IDLE);
    next_pump_enable   = (next_state != ST_IDLE) && (next_state != ST_ADDR_GAP);
    next_program_pulse = (state == ST_PULSE) && (next_state == ST_PULSE)
                         && (op_kind == OP_PROGRAM);
    next_erase_pulse   = (state == ST_PULSE) && (next_state == ST_PULSE)
                         && (op_kind == OP_ERASE);
  end

  // Shared phase timer, reloaded on entry to each timed phase, start through end.
  prescaled_down_counter phase_timer (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .load     (timer_load),
    .prescale (op_set.timing_prescale_value),
    .count    (timer_count),
    .expire   (timer_expire)
  );

  // Registers the sequencer and all outputs.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state          <= ST_IDLE;
      op_set         <= '0;
      op_kind        <= OP_PROGRAM;
      gap_cnt        <= '0;
      busy           <= 1'b0;
      op_done        <= 1'b0;
      op_refused     <= 1'b0;
      timing_warning <= 1'b0;
      pump_enable    <= 1'b0;
      program_pulse  <= 1'b0;
      erase_pulse    <= 1'b0;
      array_select   <= ARRAY_PMEM;
      flash_addr     <= '0;
    end else begin
      state          <= next_state;
      op_set         <= next_op_set;
      op_kind        <= next_op_kind;
      gap_cnt        <= next_gap_cnt;
      busy           <= next_busy;
      op_done        <= next_op_done;
      op_refused     <= next_op_refused;
      timing_warning <= next_timing_warning;
      pump_enable    <= next_pump_enable;
      program_pulse  <= next_program_pulse;
      erase_pulse    <= next_erase_pulse;
      array_select   <= next_array_select;
      flash_addr     <= next_flash_addr;
    end
  end

endmodule // flash_program_erase_timing

// ==== flash_timing_asserts.sv ====
// Concurrent checks on the ports of the flash program/erase sequencer.
`timescale 1ns/1ps
module flash_timing_asserts (
  input wire logic                                clk_sys,
  input wire logic                                rst,
  input wire logic                                op_start,
  input wire flash_timing_pkg::op_request_t       op_request,
  input wire logic                                busy,
  input wire logic                                op_done,
  input wire logic                                op_refused,
  input wire logic                                pump_enable,
  input wire logic                                program_pulse,
  input wire logic                                erase_pulse,
  input wire flash_timing_pkg::array_sel_t        array_select,
  input wire logic [flash_timing_pkg::ADDR_W-1:0] flash_addr
);
  import flash_timing_pkg::*;
  // All checks run on the system clock and rest while reset is high.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_PULSE_NEEDS_PUMP: assert property ((program_pulse || erase_pulse) |-> pump_enable)
    else $error("pulse seen with charge pump off");
  AST_PUMP_LEADS: assert property (
      $rose(program_pulse || erase_pulse) |-> $past(pump_enable))
    else $error("pump not on a cycle before the pulse");
  AST_PUMP_TRAILS: assert property ($fell(program_pulse || erase_pulse) |-> pump_enable)
    else $error("pump dropped with the pulse");
  AST_ONE_PULSE_KIND: assert property (!(program_pulse && erase_pulse))
    else $error("program and erase pulse together");
  AST_ADDR_HELD: assert property (
      busy && $past(busy) |-> $stable(flash_addr) && $stable(array_select))
    else $error("address or array moved during an operation");
  AST_ACCEPT: assert property (op_start && !busy |=> busy && pump_enable
      && flash_addr == $past(op_request.addr) && array_select == $past(op_request.array))
    else $error("request not taken as sent");
  AST_REFUSE: assert property (op_start && busy |=> op_refused)
    else $error("request while busy not refused");
  AST_DONE_PUMP_OFF: assert property (op_done |-> $fell(pump_enable))
    else $error("done without pump falling");
  AST_ADDR_TAIL: assert property (op_done |-> busy ##1 busy)
    else $error("address released too soon after done");
  AST_IDLE_QUIET: assert property (
      !busy |-> !pump_enable && !program_pulse && !erase_pulse)
    else $error("pump or pulse active while idle");
  AST_DONE_BOUND: assert property ($rose(busy) |-> ##[1:1000] op_done)
    else $error("operation did not finish");
endmodule // flash_timing_asserts

bind flash_program_erase_timing flash_timing_asserts u_chk (.clk_sys(clk_sys), .rst(rst),
  .op_start(op_start), .op_request(op_request), .busy(busy), .op_done(op_done),
  .op_refused(op_refused), .pump_enable(pump_enable), .program_pulse(program_pulse),
  .erase_pulse(erase_pulse), .array_select(array_select), .flash_addr(flash_addr));

// ==== flash_array_model.sv ====
// Behavioural flash array and charge pump that time what the sequencer drives.
`timescale 1ns/1ps
module flash_array_model (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic pump_enable,
  input  wire logic program_pulse,
  input  wire logic erase_pulse,
  output int        pulse_len,
  output int        pump_len,
  output logic      hv_fault,
  output logic      last_erase
);
  int pulse_run;
  int pump_run;
  // Measures each pulse and pump-on span; flags high voltage with the pump off.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pulse_run <= 0;
      pump_run  <= 0;
      pulse_len <= 0;
      pump_len  <= 0;
      hv_fault  <= 1'b0;
      last_erase <= 1'b0;
    end else begin
      // Remembers which kind of pulse the array saw last.
      if (erase_pulse) last_erase <= 1'b1;
      else if (program_pulse) last_erase <= 1'b0;
      if (program_pulse || erase_pulse) pulse_run <= pulse_run + 1;
      else if (pulse_run != 0) begin
        pulse_len <= pulse_run;
        pulse_run <= 0;
      end
      if (pump_enable) pump_run <= pump_run + 1;
      else if (pump_run != 0) begin
        pump_len <= pump_run;
        pump_run <= 0;
      end
      if ((program_pulse || erase_pulse) && !pump_enable) hv_fault <= 1'b1;
    end
  end
endmodule // flash_array_model

// ==== testbench.sv ====
// Self-checking testbench for the flash program/erase timing sequencer.
`timescale 1ns/1ps
module testbench;
  import flash_timing_pkg::*;
  logic              clk_sys, rst, op_start;
  op_request_t       op_request;
  timing_set_t       pset, dset;
  logic              busy, op_done, op_refused, timing_warning;
  logic              pump_enable, program_pulse, erase_pulse, hv_fault, last_erase;
  array_sel_t        array_select;
  logic [ADDR_W-1:0] flash_addr;
  int                pulse_len, pump_len, n_mismatch, n_tests;

  // Minimum windows are shrunk so short simulated phases meet them; the program maximum
  // keeps its default, far above every simulated pulse.
  flash_program_erase_timing #(.PROG_MIN_CYC(3), .ERASE_MIN_CYC(8), .START_MIN_CYC(2),
    .TRAN_MIN_CYC(2), .END_MIN_CYC(2)) uut (.clk_sys(clk_sys), .rst(rst),
    .pmem_prescale_reg(pset.timing_prescale_value),
    .pmem_program_time_reg(pset.program_pulse_count),
    .pmem_erase_time_reg(pset.erase_pulse_count),
    .pmem_start_time_reg(pset.start_delay_count),
    .pmem_transition_time_reg(pset.transition_delay_count),
    .pmem_end_time_reg(pset.end_delay_count),
    .dmem_prescale_reg(dset.timing_prescale_value),
    .dmem_program_time_reg(dset.program_pulse_count),
    .dmem_erase_time_reg(dset.erase_pulse_count),
    .dmem_start_time_reg(dset.start_delay_count),
    .dmem_transition_time_reg(dset.transition_delay_count),
    .dmem_end_time_reg(dset.end_delay_count),
    .op_start(op_start), .op_request(op_request), .busy(busy), .op_done(op_done),
    .op_refused(op_refused), .timing_warning(timing_warning), .pump_enable(pump_enable),
    .program_pulse(program_pulse), .erase_pulse(erase_pulse), .array_select(array_select),
    .flash_addr(flash_addr));
  flash_array_model u_flash (.clk_sys(clk_sys), .rst(rst), .pump_enable(pump_enable),
    .program_pulse(program_pulse), .erase_pulse(erase_pulse), .pulse_len(pulse_len),
    .pump_len(pump_len), .hv_fault(hv_fault), .last_erase(last_erase));

  // System clock, 10 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Waits, under a bound, until the sequencer is idle again.
  task automatic wait_idle();
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 2000) begin
      @(negedge clk_sys);
      i++;
    end
    check("idle reached", 32'(i < 2000), 32'h1);
  endtask

  // Sends one request for one clock and waits for the operation to end.
  task automatic run_op(input array_sel_t a, input flash_op_t o, input logic [ADDR_W-1:0] ad);
    @(negedge clk_sys);
    op_request = '{array: a, op: o, addr: ad};
    op_start = 1'b1;
    @(negedge clk_sys);
    op_start = 1'b0;
    wait_idle();
    check("pulse kind", 32'(last_erase), 32'(o == OP_ERASE));
  endtask

  // Checks the pump span, address, array and warning after an operation of set s.
  task automatic check_op(input timing_set_t s, input int x, input logic [ADDR_W-1:0] ad,
                          input array_sel_t a, input logic warn);
    int p;
    p = s.timing_prescale_value + 1;
    check("pump span", 32'(pump_len >= p * (s.start_delay_count + 1 + x + s.end_delay_count + 1
          + 2 * (s.transition_delay_count + 1)) + 2), 32'h1);
    check("flash_addr", flash_addr, 32'(ad));
    check("array_select", 32'(array_select), 32'(a));
    check("timing_warning", 32'(timing_warning), 32'(warn));
    check("hv_fault", 32'(hv_fault), 32'h0);
  endtask

  task automatic test_pmem_program();
    pset = '{8'h01, 8'h03, 8'h02, 8'h01, 8'h01, 8'h01};
    dset = '{8'h02, 8'h01, 8'h00, 8'h01, 8'h01, 8'h01};
    run_op(ARRAY_PMEM, OP_PROGRAM, 16'h1234);
    check("pmem program width", pulse_len, 32'd8);
    check_op(pset, 4, 16'h1234, ARRAY_PMEM, 1'b0);
  endtask

  task automatic test_pmem_erase();
    run_op(ARRAY_PMEM, OP_ERASE, 16'h0ffe);
    check("pmem erase width", pulse_len, 32'd24);
    check_op(pset, 12, 16'h0ffe, ARRAY_PMEM, 1'b0);
  endtask

  task automatic test_dmem_program();
    run_op(ARRAY_DMEM, OP_PROGRAM, 16'h0042);
    check("dmem program width", pulse_len, 32'd6);
    check_op(dset, 2, 16'h0042, ARRAY_DMEM, 1'b0);
  endtask

  task automatic test_isp_erase();
    run_op(ARRAY_ISP, OP_ERASE, 16'hbeef);
    check("isp erase width", pulse_len, 32'd12);
    check_op(dset, 4, 16'hbeef, ARRAY_ISP, 1'b0);
  endtask

  // Data re-programming: one erase, then four byte programs in a row.
  task automatic test_dmem_reprogram();
    run_op(ARRAY_DMEM, OP_ERASE, 16'h0040);
    check("dmem erase width", pulse_len, 32'd12);
    for (int b = 0; b < 4; b++) begin
      run_op(ARRAY_DMEM, OP_PROGRAM, 16'(32'h40 + b));
      check("dmem byte width", pulse_len, 32'd6);
      check("dmem byte address", flash_addr, 32'h40 + 32'(b));
    end
  endtask

  // A second request and a changed count during an operation leave it untouched.
  task automatic test_refuse();
    @(negedge clk_sys);
    op_request = '{array: ARRAY_PMEM, op: OP_PROGRAM, addr: 16'h5555};
    op_start = 1'b1;
    @(negedge clk_sys);
    op_start = 1'b0;
    repeat (3) @(negedge clk_sys);
    pset.program_pulse_count = 8'h09;
    op_request = '{array: ARRAY_DMEM, op: OP_ERASE, addr: 16'haaaa};
    op_start = 1'b1;
    @(negedge clk_sys);
    op_start = 1'b0;
    check("op_refused", 32'(op_refused), 32'h1);
    wait_idle();
    check("snapshot width", pulse_len, 32'd8);
    check("kept address", flash_addr, 32'h5555);
    pset.program_pulse_count = 8'h03;
  endtask

  // A one-cycle program pulse is below the window and must be flagged.
  task automatic test_warning();
    pset = '{8'h00, 8'h00, 8'h02, 8'h01, 8'h01, 8'h01};
    run_op(ARRAY_PMEM, OP_PROGRAM, 16'h0001);
    check("short program width", pulse_len, 32'd1);
    check_op(pset, 1, 16'h0001, ARRAY_PMEM, 1'b1);
  endtask

  // Watchdog that cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end

  // Main sequence: reset for five clocks, then each scenario in turn.
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    rst = 1'b1;
    op_start = 1'b0;
    op_request = '0;
    pset = '0;
    dset = '0;
    repeat (5) @(negedge clk_sys);
    check("busy in reset", 32'(busy), 32'h0);
    rst = 1'b0;
    test_pmem_program();
    test_pmem_erase();
    test_dmem_program();
    test_isp_erase();
    test_dmem_reprogram();
    test_refuse();
    test_warning();
    summarize();
  end
endmodule // testbench
